// ===== rtl/sfrpg_pkg.sv
package sfrpg_pkg;
   localparam logic [7:0] SFRPG_ADDR_CONTROL = 8'h96;
   localparam logic [7:0] SFRPG_ADDR_ACTIVE  = 8'h84;
   localparam logic [7:0] SFRPG_ADDR_MIDDLE  = 8'h85;
   localparam logic [7:0] SFRPG_ADDR_BOTTOM  = 8'h86;
   localparam int         SFRPG_EN_BIT       = 0;
   localparam logic [7:0] SFRPG_CONTROL_RST  = 8'h01;
   localparam logic [7:0] SFRPG_PAGE_RST     = 8'h00;
   localparam logic [7:0] SFRPG_EMPTY_PAGE   = 8'h00;
   localparam logic [7:0] SFRPG_PORT0        = 8'h80;
   localparam logic [7:0] SFRPG_PORT1        = 8'h90;
   localparam logic [7:0] SFRPG_PORT2        = 8'hA0;
   localparam logic [7:0] SFRPG_PORT3        = 8'hB0;

   // one direct access from the core
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfrpg_acc_t;

   // interrupt sequencer events
   typedef struct packed {
      logic       entry;
      logic [7:0] src_page;
      logic       ret;
   } sfrpg_irq_t;
endpackage : sfrpg_pkg

// ===== rtl/sfrpg_stack.sv
`timescale 1ns/10ps
module sfrpg_stack
   import sfrpg_pkg::*;
#(
   parameter int N_ALL_PAGE = 4
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             nrst,
   // core direct-address access
   input  wire sfrpg_acc_t       acc,
   input  wire logic [7:0]       all_page_addr [N_ALL_PAGE],
   // interrupt sequencer
   input  wire sfrpg_irq_t       irq,
   // outputs
   output logic [7:0]            rdata,
   output logic                  rvalid,
   output logic [7:0]            active_page_reg,
   output logic [7:0]            page_stack_middle,
   output logic [7:0]            page_stack_bottom,
   output logic [7:0]            paging_control_reg,
   output logic [7:0]            sel_page,
   output logic                  sel_all_page,
   output logic                  sel_paged
);
   // the stack is three bytes deep: active on top, then middle, then bottom.
   // the core sequencer is trusted to raise entry only when it vectors and
   // ret only when the return instruction retires; nothing else moves it.

   // which block register a direct address names
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_ACTIVE,
      SEL_MIDDLE,
      SEL_BOTTOM,
      SEL_CONTROL
   } sfrpg_reg_sel_t;

   // address matches one of the all-page register addresses
   function automatic logic is_all_page(input logic [7:0] a,
                                        input logic [7:0] lst [N_ALL_PAGE]);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < N_ALL_PAGE; i++) begin
         if (a == lst[i]) hit = 1'b1;
      end
      return hit;
   endfunction : is_all_page

   // address to block register; unmatched addresses belong to other blocks
   function automatic sfrpg_reg_sel_t decode_reg(input logic [7:0] a);
      sfrpg_reg_sel_t sel;
      sel = SEL_NONE;
      if (a == SFRPG_ADDR_ACTIVE) begin
         sel = SEL_ACTIVE;
      end else if (a == SFRPG_ADDR_MIDDLE) begin
         sel = SEL_MIDDLE;
      end else if (a == SFRPG_ADDR_BOTTOM) begin
         sel = SEL_BOTTOM;
      end else if (a == SFRPG_ADDR_CONTROL) begin
         sel = SEL_CONTROL;
      end
      return sel;
   endfunction : decode_reg

   // stack group state and next values
   logic [7:0]     next_active;
   logic [7:0]     next_middle;
   logic [7:0]     next_bottom;
   logic           next_bottom_valid;
   logic           bottom_valid;          // a saved page sits at the bottom
   // control group next value
   logic [7:0]     next_control;
   // read and select group next values
   logic [7:0]     next_rdata;
   logic           next_rvalid;
   logic [7:0]     next_sel_page;
   logic           next_sel_all;
   logic           next_sel_paged;
   // qualified events and decoded store target
   logic           auto_paging_enable;
   logic           do_push;
   logic           do_pop;
   sfrpg_reg_sel_t wr_sel;

   // enable bit straight from the control register
   assign auto_paging_enable = paging_control_reg[SFRPG_EN_BIT];

   // entry wins over a return in the same cycle; both are dead when disabled
   assign do_push = auto_paging_enable & irq.entry;
   assign do_pop  = auto_paging_enable & irq.ret & ~irq.entry;

   // only a write selects a store target, so reads never disturb the stack
   assign wr_sel = acc.wr ? decode_reg(acc.addr) : SEL_NONE;

   // stack next state; a hardware move beats a software store in one cycle
   always_comb begin
      next_active       = active_page_reg;
      next_middle       = page_stack_middle;
      next_bottom       = page_stack_bottom;
      next_bottom_valid = bottom_valid;
      if (do_push) begin
         // bottom loses whatever it held, a software value included
         next_bottom       = page_stack_middle;
         next_bottom_valid = 1'b1;
         next_middle       = active_page_reg;
         next_active       = irq.src_page;
      end else if (do_pop) begin
         // an empty bottom shows up as page zero in the middle
         next_active       = page_stack_middle;
         next_middle       = bottom_valid ? page_stack_bottom : SFRPG_EMPTY_PAGE;
         next_bottom_valid = 1'b0;
      end else begin
         // plain stores, no stack motion
         case (wr_sel)
            SEL_ACTIVE: begin
               next_active = acc.wdata;
            end
            SEL_MIDDLE: begin
               next_middle = acc.wdata;
            end
            SEL_BOTTOM: begin
               next_bottom       = acc.wdata;
               next_bottom_valid = 1'b1;
            end
            default: begin
               next_bottom_valid = bottom_valid;
            end
         endcase
      end
   end

   // control next state; reserved bits are never stored so they read zero
   always_comb begin
      next_control = paging_control_reg;
      if (wr_sel == SEL_CONTROL) begin
         next_control = {7'h00, acc.wdata[SFRPG_EN_BIT]};
      end
   end

   // read and select path; the page handed out is the one before this edge,
   // so a page write counts from the following access on
   always_comb begin
      next_rdata     = 8'h00;
      next_rvalid    = acc.rd;
      next_sel_all   = is_all_page(acc.addr, all_page_addr);
      next_sel_paged = (acc.rd | acc.wr) & ~next_sel_all;
      next_sel_page  = active_page_reg;
      case (decode_reg(acc.addr))
         SEL_ACTIVE: begin
            next_rdata = active_page_reg;
         end
         SEL_MIDDLE: begin
            next_rdata = page_stack_middle;
         end
         SEL_BOTTOM: begin
            next_rdata = page_stack_bottom;
         end
         SEL_CONTROL: begin
            next_rdata = paging_control_reg;
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // stack registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         active_page_reg   <= SFRPG_PAGE_RST;
         page_stack_middle <= SFRPG_PAGE_RST;
         page_stack_bottom <= SFRPG_PAGE_RST;
         bottom_valid      <= 1'b0;
      end else begin
         active_page_reg   <= next_active;
         page_stack_middle <= next_middle;
         page_stack_bottom <= next_bottom;
         bottom_valid      <= next_bottom_valid;
      end
   end

   // control register, enabled out of reset
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         paging_control_reg <= SFRPG_CONTROL_RST;
      end else begin
         paging_control_reg <= next_control;
      end
   end

   // read data and select outputs, each a one-cycle registered answer
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata        <= 8'h00;
         rvalid       <= 1'b0;
         sel_page     <= SFRPG_PAGE_RST;
         sel_all_page <= 1'b0;
         sel_paged    <= 1'b0;
      end else begin
         rdata        <= next_rdata;
         rvalid       <= next_rvalid;
         sel_page     <= next_sel_page;
         sel_all_page <= next_sel_all;
         sel_paged    <= next_sel_paged;
      end
   end
endmodule : sfrpg_stack

// ===== bench/sfrpg_irq_model.sv
`timescale 1ns/10ps
module sfrpg_irq_model
   import sfrpg_pkg::*;
(
   // event lines toward the block
   output sfrpg_irq_t irq
);
   initial irq = '0;
   // pulses last one call; idle page toggles so a stale page is never trusted
   task automatic send(input logic ent, ret, input logic [7:0] pg);
      irq = '{ent, ent ? pg : ~irq.src_page, ret};
   endtask : send
endmodule : sfrpg_irq_model

// ===== bench/sfrpg_stack_assertions.sv
`timescale 1ns/10ps
module sfrpg_stack_assertions
   import sfrpg_pkg::*;
#(parameter int N_ALL_PAGE = 4) (
   // watched block ports
   input wire logic       clock, nrst, rvalid, sel_all_page, sel_paged,
   input wire sfrpg_acc_t acc,
   input wire sfrpg_irq_t irq,
   input wire logic [7:0] all_page_addr [N_ALL_PAGE],
   input wire logic [7:0] rdata, active_page_reg, page_stack_middle, page_stack_bottom,
   input wire logic [7:0] paging_control_reg, sel_page
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // short aliases keep the properties on one line
   wire       en  = paging_control_reg[0];
   wire [7:0] act = active_page_reg, mid = page_stack_middle, bot = page_stack_bottom;
   a_entry_page: assert property (irq.entry && en |=> act == $past(irq.src_page))
      else $error("entry page");
   a_push_shift: assert property (irq.entry && en |=> mid == $past(act) && bot == $past(mid))
      else $error("push");
   a_pop_shift: assert property (irq.ret && !irq.entry && en |=> act == $past(mid))
      else $error("pop");
   a_quiet_hold: assert property ((!en || !irq.entry && !irq.ret) && !acc.wr |=> $stable({act, mid, bot}))
      else $error("stack moved");
   a_sw_active: assert property (acc.wr && acc.addr == 8'h84 && !irq.entry && !irq.ret |=>
      act == $past(acc.wdata) && $stable(mid)) else $error("page write");
   a_ctl_reserved: assert property (paging_control_reg[7:1] == 7'h00)
      else $error("reserved bits");
   a_read_mid: assert property (acc.rd && acc.addr == 8'h85 |=> rvalid && rdata == $past(mid))
      else $error("middle read");
   a_all_page: assert property (acc.rd && acc.addr == all_page_addr[0] |=> sel_all_page && !sel_paged)
      else $error("all page");
   a_sel_page: assert property (acc.rd || acc.wr |=> sel_page == $past(act))
      else $error("page select");
endmodule : sfrpg_stack_assertions
bind sfrpg_stack sfrpg_stack_assertions #(.N_ALL_PAGE(N_ALL_PAGE)) u_chk (.*);

// ===== bench/sfrpg_stack_test.sv
`timescale 1ns/10ps
module sfrpg_stack_test;
   import sfrpg_pkg::*;
   logic       clock = 0, nrst = 0, rvalid, sel_all_page, sel_paged, bv = 0, en = 1;
   logic [7:0] rdata, active_page_reg, page_stack_middle, page_stack_bottom, paging_control_reg;
   logic [7:0] sel_page, a = 0, m = 0, b = 0, e, p;
   logic       ap;
   logic [7:0] all_page_addr [4] = '{SFRPG_PORT0, SFRPG_PORT1, SFRPG_PORT2, SFRPG_PORT3};
   logic [7:0] adr [8] = '{8'h84, 8'h85, 8'h86, 8'h96, SFRPG_PORT0, SFRPG_PORT1, SFRPG_PORT2,
      SFRPG_PORT3};
   logic [23:0] dir [14] = '{24'h02_9600, 24'h01_840F, 24'h03_0002, 24'h01_8633, 24'h03_0000,
      24'h02_8500, 24'h04_0000, 24'h04_0000, 24'h02_8000, 24'h01_96FE, 24'h03_0005,
      24'h04_0000, 24'h01_96FF, 24'h02_9600};
   sfrpg_acc_t acc = '0;
   sfrpg_irq_t irq;
   int         error_cnt = 0, n_tests = 0, cyc = 0, seed = 26990;
   sfrpg_irq_model u_seq (.irq(irq));
   sfrpg_stack DUT (.*);
   initial forever #4 clock = ~clock;
   // hang guard, far above the few hundred steps of the run
   always @(posedge clock) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic chk(input string n, input logic [7:0] x, s);
      n_tests++;
      if (s !== x) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   // op 1 write, 2 read, 3 entry, 4 return; read result is taken before the model moves
   task automatic step(input int op, input logic [7:0] ad, d);
      acc = '{op == 1, op == 2, ad, d};
      u_seq.send(op == 3, op == 4, d);
      e = ad == 8'h84 ? a : ad == 8'h85 ? m : ad == 8'h86 ? b : ad == 8'h96 ? {7'h00, en} : 8'h00;
      p = a;
      ap = ad == SFRPG_PORT0 || ad == SFRPG_PORT1 || ad == SFRPG_PORT2 || ad == SFRPG_PORT3;
      @(posedge clock);
      #1;
      if (op == 2) chk("rdata", e, rdata);
      chk("rvalid", {7'h00, op == 2}, {7'h00, rvalid});
      chk("sel_all_page", {7'h00, ap}, {7'h00, sel_all_page});
      chk("sel_paged", {7'h00, (op == 1 || op == 2) && !ap}, {7'h00, sel_paged});
      chk("sel_page", p, sel_page);
      if (en && op == 3) {b, m, a, bv} = {m, a, d, 1'b1};
      else if (en && op == 4) {a, m, bv} = {m, bv ? b : 8'h00, 1'b0};
      else if (op == 1 && ad == 8'h84) a = d;
      else if (op == 1 && ad == 8'h85) m = d;
      else if (op == 1 && ad == 8'h86) {b, bv} = {d, 1'b1};
      else if (op == 1 && ad == 8'h96) en = d[0];
      chk("active", a, active_page_reg);
      chk("middle", m, page_stack_middle);
      chk("bottom", b, page_stack_bottom);
      chk("control", {7'h00, en}, paging_control_reg);
   endtask : step
   // directed walk, then random traffic over every op and address
   initial begin
      repeat (4) @(posedge clock);
      #1;
      nrst = 1;
      foreach (dir[i]) step(dir[i][23:16], dir[i][15:8], dir[i][7:0]);
      repeat (300) step($unsigned($random(seed)) % 5, adr[$unsigned($random(seed)) % 8], 8'($random(seed)));
      end_of_test();
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test
endmodule : sfrpg_stack_test
